// >>> hdl/ccc_pkg.sv
package ccc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ           = 200;
  localparam int REFRESH_PERIOD_US = 16;
  localparam int REFRESH_CYCLES    = REFRESH_PERIOD_US * CLK_MHZ;
  localparam int SLOT_COUNT        = 8;
  localparam int OCTAVE_COUNT      = 8;
  localparam int JITTER_DIV        = 16;

  // ****************************************
  // Host register map (index within 16)
  // ****************************************
  localparam logic [3:0] REG_CARD_STATUS = 4'h0;
  localparam logic [3:0] REG_CPU_RESET   = 4'h1;
  localparam logic [3:0] REG_PAGE_ONE    = 4'h2;
  localparam logic [3:0] REG_PAGE_TWO    = 4'h3;
  localparam logic [3:0] REG_LOCAL_IRQ   = 4'h4;

  // ****************************************
  // Local I/O map
  // ****************************************
  localparam logic [15:0] LOCAL_IO_BASE   = 16'hFE80;
  localparam logic [15:0] LOCAL_IO_SECOND = 16'hFEC0;
  localparam logic [5:0]  IO_CONTROL      = 6'h00;
  localparam logic [5:0]  IO_PITCH_A_LO   = 6'h04;
  localparam logic [5:0]  IO_PITCH_A_HI   = 6'h05;
  localparam logic [5:0]  IO_PITCH_B_LO   = 6'h06;
  localparam logic [5:0]  IO_PITCH_B_HI   = 6'h07;
  localparam logic [5:0]  IO_STATUS_CODE  = 6'h08;
  localparam logic [5:0]  IO_FILTER_BASE  = 6'h10;
  localparam logic [5:0]  IO_AMP_A_LO     = 6'h20;
  localparam logic [5:0]  IO_AMP_A_HI     = 6'h21;
  localparam logic [5:0]  IO_AMP_B_LO     = 6'h22;
  localparam logic [5:0]  IO_AMP_B_HI     = 6'h23;
  localparam logic [5:0]  IO_TRANSFER     = 6'h24;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [14:0] PITCH_RESET   = 15'h0000;

  // ****************************************
  // Control latch bits
  // ****************************************
  localparam int CTL_RUN_A    = 0;
  localparam int CTL_RUN_B    = 1;
  localparam int CTL_SMOOTH_A = 2;
  localparam int CTL_SMOOTH_B = 3;
  localparam int CTL_EOL_IE_A = 4;
  localparam int CTL_EOL_IE_B = 5;
  localparam int CTL_LOOP_A   = 6;
  localparam int CTL_LOOP_B   = 7;

  typedef enum logic [1:0] {
    ADDR_LOCAL,
    ADDR_PAGE,
    ADDR_HOST_LOW
  } ccc_addr_src_type;

  typedef struct packed {
    logic        card_select_n;
    logic        page_select;
    logic        host_sel_two;
    logic        refresh;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } ccc_host_bus_type;

  typedef struct packed {
    logic [1:0]  filter_sel;
    logic        filter_we;
    logic [7:0]  filter_code;
    logic [11:0] amp_a;
    logic [11:0] amp_b;
  } ccc_cv_type;

endpackage

// >>> hdl/ccc_channel_card_control.sv
`timescale 1ns/1ps
// Operation
// (R1) Host sees sixteen registers, two 256-byte windows
// (R2) Host accesses steal a local processor cycle
// (R3) Refresh steals one cycle per sixteen microseconds
// (R4) One waveform slot shared by both channels
// (R5) Take slot on token, assert slot_taken
// (R6) Transceiver off for host, refresh, local I/O
// (R7) Two host page registers loaded from data path
// (R8) DRAM address from local, page or host
// (R9) Refresh row seven bits, page offset eight
// (R10) Local clock gated by select and refresh
// (R11) Register decode when select low, window high
// (R12) Local I/O two 64-byte blocks at FE80
// (R13) Local I/O access disables data transceiver
// (R14) Pitch: 3-bit octave, 12-bit rate multiplier
// (R15) Counter gives eight octaves, one selected
// (R16) Divide-by-sixteen filter, gated by run
// (R17) Status: four host flags plus local code
// (R18) Control latch cleared at power-on
// (R19) Reset flip-flop host-only, cleared at power-on
// (R20) Converters reachable only from local processor
// (R21) Filter converter byte-selected by low address
// (R22) Amplitude takes effect after transfer strobe
// (R23) Slot token low one slice in eight
// (R24) E and Q clocks supplied by support board
// (R25) Host loads page before window access
module ccc_channel_card_control (
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  input  wire ccc_pkg::ccc_host_bus_type host_i,
  input  wire logic                      clk_e_i,
  input  wire logic                      clk_q_i,
  input  wire logic                      slot_token_n_i,
  input  wire logic                      slice_tick_i,
  input  wire logic                      pitch_tick_i,
  input  wire logic                      engine_request_i,
  input  wire logic                      engine_irq_i,
  input  wire logic                      local_valid_i,
  input  wire logic                      local_write_i,
  input  wire logic [15:0]               local_addr_i,
  input  wire logic [7:0]                local_data_i,
  output logic [7:0]                     host_rdata_o,
  output logic                           local_clk_e_o,
  output logic                           local_clk_q_o,
  output logic                           local_reset_n_o,
  output logic                           local_irq_o,
  output logic                           transceiver_en_o,
  output logic [7:0]                     dram_addr_o,
  output logic                           slot_taken_o,
  output logic                           sample_clk_a_o,
  output logic                           sample_clk_b_o,
  output logic [7:0]                     control_o,
  output ccc_pkg::ccc_cv_type            cv_o
);
  import ccc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]  sel_meta;
    logic [1:0]  sel_sync;
    logic [1:0]  eq_meta;
    logic [1:0]  eq_sync;
    logic        tok_meta;
    logic        tok_sync;
    logic [15:0] ref_count;
    logic        ref_pending;
    logic        e_prev;
    logic [7:0]  page_one;
    logic [7:0]  page_two;
    logic        cpu_run;
    logic        local_irq;
    logic [3:0]  status_code;
    logic [7:0]  control;
    logic [14:0] pitch_a;
    logic [14:0] pitch_b;
    logic [11:0] rate_acc_a;
    logic [11:0] rate_acc_b;
    logic [7:0]  oct_cnt_a;
    logic [7:0]  oct_cnt_b;
    logic        oct_prev_a;
    logic        oct_prev_b;
    logic [3:0]  jit_a;
    logic [3:0]  jit_b;
    logic        slot_owner;
    logic [15:0] amp_stage_a;
    logic [15:0] amp_stage_b;
    logic [7:0]  rdata;
    logic        clk_e;
    logic        clk_q;
    logic        reset_n;
    logic        irq;
    logic        xcvr;
    logic [7:0]  dram_addr;
    logic        slot_taken;
    logic        samp_a;
    logic        samp_b;
    ccc_cv_type  cv;
  } ccc_state_type;

  ccc_state_type r;
  ccc_state_type next_r;

  logic             host_active;
  logic             reg_access;
  logic             window_access;
  logic             local_io;
  logic             local_io_first;
  logic [5:0]       io_off;
  ccc_addr_src_type addr_src;
  logic             oct_sel_a;
  logic             oct_sel_b;
  logic             carry_a;
  logic             carry_b;

  always_comb begin
    next_r = r;
    // ****************************************
    // Synchronisers
    // ****************************************
    // Host bus fields are same-domain latched strobes
    next_r.sel_meta = {host_i.page_select, ~host_i.card_select_n};
    next_r.sel_sync = r.sel_meta;
    next_r.eq_meta  = {clk_q_i, clk_e_i};
    next_r.eq_sync  = r.eq_meta;
    next_r.tok_meta = slot_token_n_i;
    next_r.tok_sync = r.tok_meta;

    // ****************************************
    // Decode
    // ****************************************
    host_active    = r.sel_sync[0];
    reg_access     = host_active & r.sel_sync[1]; // [R11]
    window_access  = host_active & ~r.sel_sync[1]; // [R1]
    local_io       = local_valid_i & (local_addr_i[15:7] == LOCAL_IO_BASE[15:7]); // [R12]
    local_io_first = local_io & (local_addr_i[15:6] == LOCAL_IO_BASE[15:6]);
    io_off         = local_addr_i[5:0];

    // ****************************************
    // Refresh: count the period, steal one cycle of the local clock
    // ****************************************
    // Pending ends on a host refresh or after one stolen E phase, so a
    // missing refresh cannot freeze the local processor for good
    next_r.e_prev = r.eq_sync[0];
    if (host_i.refresh) begin
      next_r.ref_pending = 1'b0;
    end
    if (r.ref_pending & r.e_prev & ~r.eq_sync[0]) begin
      next_r.ref_pending = 1'b0;
    end
    // Period tick comes last so it wins over a same-cycle clear
    if (r.ref_count == 16'(REFRESH_CYCLES - 1)) begin
      next_r.ref_count   = 16'h0000;
      next_r.ref_pending = 1'b1; // [R3]
    end else begin
      next_r.ref_count = r.ref_count + 16'h0001;
    end

    // ****************************************
    // Local clock stopped while host or refresh owns memory
    // ****************************************
    next_r.clk_e = r.eq_sync[0] & ~host_active & ~host_i.refresh & ~r.ref_pending; // [R10] [R2] [R3]
    next_r.clk_q = r.eq_sync[1] & ~host_active & ~host_i.refresh & ~r.ref_pending; // [R10]

    // ****************************************
    // Transceiver closed so host data never reaches peripheral side
    // ****************************************
    next_r.xcvr = ~(host_active | host_i.refresh | local_io); // [R6] [R13]

    // ****************************************
    // DRAM address multiplexer
    // ****************************************
    if (host_i.refresh) begin
      addr_src = ADDR_HOST_LOW;
    end else if (window_access) begin
      addr_src = ADDR_HOST_LOW;
    end else begin
      addr_src = ADDR_LOCAL;
    end
    if (window_access & r.eq_sync[1]) begin
      addr_src = ADDR_PAGE; // column phase carries the page
    end
    unique case (addr_src)
      ADDR_LOCAL:    next_r.dram_addr = r.eq_sync[1] ? local_addr_i[15:8] : local_addr_i[7:0]; // [R8]
      ADDR_PAGE:     next_r.dram_addr = host_i.host_sel_two ? r.page_two : r.page_one; // [R7] [R8]
      ADDR_HOST_LOW: next_r.dram_addr = host_i.refresh ? {1'b0, host_i.addr[6:0]} : host_i.addr[7:0]; // [R9]
    endcase

    // ****************************************
    // Host register file
    // ****************************************
    next_r.rdata = 8'h00;
    if (reg_access) begin
      unique case (host_i.addr[3:0])
        REG_CARD_STATUS: begin
          if (!host_i.write) begin
            next_r.rdata = {engine_irq_i, ~r.cpu_run, r.control[CTL_RUN_A], r.control[CTL_RUN_B],
                            r.status_code}; // [R17]
          end
        end
        REG_CPU_RESET: begin
          if (host_i.write) begin
            next_r.cpu_run = host_i.data[0]; // [R19]
          end
        end
        REG_PAGE_ONE: begin
          if (host_i.write) begin
            next_r.page_one = host_i.data; // [R7]
          end
        end
        REG_PAGE_TWO: begin
          if (host_i.write) begin
            next_r.page_two = host_i.data; // [R7]
          end
        end
        REG_LOCAL_IRQ: begin
          if (host_i.write) begin
            next_r.local_irq = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // Local I/O: latch, pitch, status code, converters
    // ****************************************
    next_r.cv.filter_we = 1'b0;
    if (local_io_first & local_write_i) begin
      unique case (io_off)
        IO_CONTROL: begin
          next_r.control = local_data_i; // [R18]
        end
        IO_PITCH_A_LO: begin
          next_r.pitch_a[7:0] = local_data_i; // [R14]
        end
        IO_PITCH_A_HI: begin
          next_r.pitch_a[14:8] = local_data_i[6:0];
        end
        IO_PITCH_B_LO: begin
          next_r.pitch_b[7:0] = local_data_i;
        end
        IO_PITCH_B_HI: begin
          next_r.pitch_b[14:8] = local_data_i[6:0];
        end
        IO_STATUS_CODE: begin
          next_r.status_code = local_data_i[3:0]; // [R17]
        end
        IO_AMP_A_LO: begin
          next_r.amp_stage_a[7:0] = local_data_i; // [R22]
        end
        IO_AMP_A_HI: begin
          next_r.amp_stage_a[15:8] = local_data_i;
        end
        IO_AMP_B_LO: begin
          next_r.amp_stage_b[7:0] = local_data_i;
        end
        IO_AMP_B_HI: begin
          next_r.amp_stage_b[15:8] = local_data_i;
        end
        default: begin
        end
      endcase
      if (io_off[5:2] == IO_FILTER_BASE[5:2]) begin
        next_r.cv.filter_sel  = io_off[1:0]; // [R21] [R20]
        next_r.cv.filter_code = local_data_i;
        next_r.cv.filter_we   = 1'b1;
      end
    end
    if (local_io_first & (io_off == IO_TRANSFER)) begin
      next_r.cv.amp_a = r.amp_stage_a[11:0]; // [R22]
      next_r.cv.amp_b = r.amp_stage_b[11:0];
    end
    if (local_io_first & (io_off == IO_CONTROL) & ~local_write_i) begin
      next_r.local_irq = 1'b0; // host interrupt acknowledged locally
    end
    if (reg_access & host_i.write & (host_i.addr[3:0] == REG_LOCAL_IRQ)) begin
      next_r.local_irq = 1'b1; // set wins over a same-cycle acknowledge
    end

    // ****************************************
    // Pitch: rate multiplier drops pulses from the master tick
    // ****************************************
    oct_sel_a = 1'b0;
    oct_sel_b = 1'b0;
    carry_a   = 1'b0;
    carry_b   = 1'b0;
    if (pitch_tick_i) begin
      {carry_a, next_r.rate_acc_a} = {1'b0, r.rate_acc_a} + {1'b0, r.pitch_a[11:0]}; // [R14]
      {carry_b, next_r.rate_acc_b} = {1'b0, r.rate_acc_b} + {1'b0, r.pitch_b[11:0]};
    end
    // Each kept pulse advances the octave chain, bit 0 is the fastest octave
    next_r.oct_cnt_a = r.oct_cnt_a + 8'(carry_a); // [R15]
    next_r.oct_cnt_b = r.oct_cnt_b + 8'(carry_b);
    oct_sel_a = r.oct_cnt_a[3'(7) - r.pitch_a[14:12]]; // [R15]
    oct_sel_b = r.oct_cnt_b[3'(7) - r.pitch_b[14:12]];
    next_r.oct_prev_a = oct_sel_a;
    next_r.oct_prev_b = oct_sel_b;
    if (oct_sel_a & ~r.oct_prev_a) next_r.jit_a = r.jit_a + 4'h1; // [R16]
    if (oct_sel_b & ~r.oct_prev_b) next_r.jit_b = r.jit_b + 4'h1;
    next_r.samp_a = r.jit_a[3] & r.control[CTL_RUN_A]; // [R16]
    next_r.samp_b = r.jit_b[3] & r.control[CTL_RUN_B];

    // ****************************************
    // Waveform slot: token low marks our slice, channels alternate
    // ****************************************
    next_r.slot_taken = 1'b0;
    if (slice_tick_i & ~r.tok_sync) begin // [R23]
      next_r.slot_owner = ~r.slot_owner; // [R4]
      next_r.slot_taken = engine_request_i; // [R5]
    end else if (r.slot_taken & ~slice_tick_i) begin
      next_r.slot_taken = 1'b1; // held for the whole slice
    end

    if (!r.control[CTL_RUN_A]) next_r.jit_a = 4'h0;
    if (!r.control[CTL_RUN_B]) next_r.jit_b = 4'h0;
    next_r.reset_n = r.cpu_run; // [R19]
    next_r.irq     = r.local_irq;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0; // control latch, pitches and reset flip-flop all clear [R18] [R19]
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign host_rdata_o     = r.rdata;
  assign local_clk_e_o    = r.clk_e;
  assign local_clk_q_o    = r.clk_q;
  assign local_reset_n_o  = r.reset_n;
  assign local_irq_o      = r.irq;
  assign transceiver_en_o = r.xcvr;
  assign dram_addr_o      = r.dram_addr;
  assign slot_taken_o     = r.slot_taken;
  assign sample_clk_a_o   = r.samp_a;
  assign sample_clk_b_o   = r.samp_b;
  assign control_o        = r.control;
  assign cv_o             = r.cv;

endmodule // ccc_channel_card_control

// >>> tb/ccc_assertions.sv
`timescale 1ns/1ps
// ****
// Checker
// ****
module ccc_checker
  import ccc_pkg::*;
(
  input wire logic                      clk_i,
  input wire logic                      arst_n_i,
  input wire ccc_pkg::ccc_host_bus_type host_i,
  input wire logic                      local_valid_i,
  input wire logic                      local_write_i,
  input wire logic [15:0]               local_addr_i,
  input wire logic [7:0]                local_data_i,
  input wire logic                      local_clk_e_o,
  input wire logic                      local_clk_q_o,
  input wire logic                      local_reset_n_o,
  input wire logic                      transceiver_en_o,
  input wire logic [7:0]                dram_addr_o,
  input wire logic                      sample_clk_a_o,
  input wire logic [7:0]                control_o,
  input wire ccc_pkg::ccc_cv_type       cv_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic wr;
  assign wr = local_valid_i & local_write_i;
  // Four cycles covers the select synchroniser before refresh is judged
  sequence s_ref;
    (host_i.refresh && $stable(host_i.addr)) [*4];
  endsequence
  sequence s_xfer;
    wr && local_addr_i == {10'h3FA, IO_TRANSFER};
  endsequence
  a_reset_clear: assert property ($past(arst_n_i) == 1'b0 |-> control_o == CONTROL_RESET && !local_reset_n_o)
    else $error("latch or local reset not clear after reset");
  a_latch_write: assert property (wr && local_addr_i == LOCAL_IO_BASE |=> control_o == $past(local_data_i))
    else $error("control latch not loaded");
  a_xcvr_io: assert property (local_valid_i && local_addr_i[15:7] == 9'h1FD |-> ##[0:2] !transceiver_en_o)
    else $error("transceiver on during local io");
  a_xcvr_refresh: assert property (s_ref |-> !transceiver_en_o)
    else $error("transceiver on during refresh");
  a_clk_stopped: assert property (s_ref |-> !local_clk_e_o && !local_clk_q_o)
    else $error("local clock runs during refresh");
  a_refresh_row: assert property (s_ref |-> dram_addr_o[6:0] == host_i.addr[6:0])
    else $error("refresh row wrong");
  a_filter_write: assert property (wr && local_addr_i[15:2] == 14'h3FA4 |=> cv_o.filter_we
    && cv_o.filter_sel == $past(local_addr_i[1:0]) && cv_o.filter_code == $past(local_data_i))
    else $error("filter converter write wrong");
  a_amp_strobe: assert property (!$stable({cv_o.amp_a, cv_o.amp_b}) |-> $past(local_valid_i && local_addr_i == {10'h3FA, IO_TRANSFER}))
    else $error("amplitude changed without transfer");
  a_run_gate: assert property (!control_o[CTL_RUN_A] [*3] |-> !sample_clk_a_o)
    else $error("sample clock while stopped");
  c_xfer: cover property (s_xfer);
endmodule // ccc_checker

bind ccc_channel_card_control ccc_checker ccc_checker_inst (.*);

// >>> tb/ccc_host_model.sv
`timescale 1ns/1ps
// ****
// Host pair model
// ****
module ccc_host_model
  import ccc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic [7:0]           rdata_i,
  output ccc_pkg::ccc_host_bus_type host_o
);
  initial begin
    host_o = '0;
    host_o.card_select_n = 1'b1;
  end
  // Released address and data show the inverse of their last value, not a held copy
  task automatic release_bus();
    host_o.card_select_n = 1'b1;
    host_o.page_select = 1'b0;
    host_o.refresh = 1'b0;
    host_o.write = 1'b0;
    host_o.addr = ~host_o.addr;
    host_o.data = ~host_o.data;
  endtask
  // Held long enough to pass the select synchroniser and catch the answer
  task automatic access(input logic two, input logic wr, input logic [3:0] idx,
                        input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    @(posedge clk_i);
    #1;
    host_o.card_select_n = 1'b0;
    host_o.page_select = 1'b1;
    host_o.host_sel_two = two;
    host_o.write = wr;
    host_o.addr = {12'hE00, idx};
    host_o.data = d;
    repeat (8) begin
      @(posedge clk_i);
      #1;
      q = q | rdata_i;
    end
    release_bus();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic refresh(input int n, input logic [6:0] row);
    @(posedge clk_i);
    #1;
    host_o.refresh = 1'b1;
    host_o.addr = {9'h000, row};
    repeat (n) @(posedge clk_i);
    #1;
    release_bus();
  endtask
endmodule // ccc_host_model

// >>> tb/ccc_channel_card_control_tb.sv
`timescale 1ns/1ps
module channel_card_control_tb;
  import ccc_pkg::*;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  exp;
  } ccc_row_type;
  logic clk_i = 0, arst_n_i = 0, clk_e_i = 0, clk_q_i = 0, slot_token_n_i = 1, slice_tick_i = 0;
  logic pitch_tick_i = 0, engine_request_i = 0, engine_irq_i = 0, local_valid_i = 0, local_write_i = 0;
  logic [15:0] local_addr_i = 16'h0000;
  logic [7:0]  local_data_i = 8'h00, host_rdata_o, dram_addr_o, control_o, q;
  logic local_clk_e_o, local_clk_q_o, local_reset_n_o, local_irq_o, transceiver_en_o;
  logic slot_taken_o, sample_clk_a_o, sample_clk_b_o;
  ccc_host_bus_type host_i;
  ccc_cv_type       cv_o;
  int err_count = 0, samples_checked = 0, cyc = 0, sc = 0, n, nb;
  ccc_row_type rows [6] = '{'{16'hFE80, 8'h05, 8'h05}, '{16'hFE80, 8'hAA, 8'hAA}, '{16'hFE90, 8'h00, 8'h00},
                            '{16'hFE91, 8'hFF, 8'hFF}, '{16'hFE92, 8'h5A, 8'h5A}, '{16'hFE93, 8'hA5, 8'hA5}};
  always #2.5 clk_i = ~clk_i;
  // Support board timing: E at 2 MHz, Q trailing by a quarter
  always #250 clk_e_i = ~clk_e_i;
  always @(clk_e_i) clk_q_i <= #125 clk_e_i;
  // 300 ns slices, token low in one slice of eight
  always @(posedge clk_i) begin
    sc <= (sc + 1) % 480;
    slice_tick_i <= #1 (sc % 60) == 0;
    slot_token_n_i <= #1 sc >= 60;
    pitch_tick_i <= #1 ~pitch_tick_i;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  ccc_channel_card_control ccc_channel_card_control_inst (.*);
  ccc_host_model ccc_host_model_inst (
    .clk_i   (clk_i),
    .rdata_i (host_rdata_o),
    .host_o  (host_i)
  );
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic lwr(input logic [5:0] off, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    {local_valid_i, local_write_i, local_addr_i, local_data_i} = {2'b11, 10'h3FA, off, d};
    @(posedge clk_i);
    #1;
    {local_valid_i, local_write_i, local_addr_i, local_data_i} = {2'b00, ~{10'h3FA, off}, ~d};
  endtask
  task automatic lrd(input logic [5:0] off);
    @(posedge clk_i);
    #1;
    {local_valid_i, local_write_i, local_addr_i} = {2'b10, 10'h3FA, off};
    @(posedge clk_i);
    #1;
    {local_valid_i, local_write_i, local_addr_i} = {2'b00, ~{10'h3FA, off}};
  endtask
  task automatic count_rises(input int len);
    logic pa, pb;
    n = 0;
    nb = 0;
    pa = sample_clk_a_o;
    pb = sample_clk_b_o;
    repeat (len) begin
      @(posedge clk_i);
      #1;
      n += int'(sample_clk_a_o & ~pa);
      nb += int'(sample_clk_b_o & ~pb);
      pa = sample_clk_a_o;
      pb = sample_clk_b_o;
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 arst_n_i = 1;
    chk("control", CONTROL_RESET, control_o);
    chk("local_reset_n", 0, local_reset_n_o);
    $display("reset test done");
    foreach (rows[i]) begin
      lwr(rows[i].addr[5:0], rows[i].data);
      if (rows[i].addr[4]) begin
        chk("filter_code", rows[i].exp, cv_o.filter_code);
        chk("filter_sel", rows[i].addr[1:0], cv_o.filter_sel);
        chk("filter_we", 1, cv_o.filter_we);
      end else chk("control", rows[i].exp, control_o);
    end
    $display("row test done");
    ccc_host_model_inst.access(0, 1, REG_CPU_RESET, 8'h01, q);
    chk("local_reset_n", 1, local_reset_n_o);
    ccc_host_model_inst.access(1, 1, REG_CPU_RESET, 8'h00, q);
    chk("local_reset_n", 0, local_reset_n_o);
    ccc_host_model_inst.access(0, 1, REG_PAGE_ONE, 8'h33, q);
    lwr(IO_STATUS_CODE, 8'h0C);
    ccc_host_model_inst.access(1, 0, REG_CARD_STATUS, 8'h00, q);
    chk("status_code", 4'hC, q[3:0]);
    chk("card_status", 8'h5C, q);
    for (int i = 5; i < 16; i++) ccc_host_model_inst.access(1, 1, 4'(i), 8'hFF, q);
    chk("control", 8'hA5 & 8'h00 | 8'hAA, control_o);
    chk("amp_a", 0, cv_o.amp_a);
    ccc_host_model_inst.access(0, 0, 4'hF, 8'h00, q);
    chk("unmapped", 0, q);
    ccc_host_model_inst.access(0, 1, REG_LOCAL_IRQ, 8'h00, q);
    chk("local_irq", 1, local_irq_o);
    lrd(IO_CONTROL);
    @(posedge clk_i);
    #1;
    chk("local_irq", 0, local_irq_o);
    $display("host test done");
    lwr(IO_AMP_A_LO, 8'h34);
    lwr(IO_AMP_A_HI, 8'h12);
    lwr(IO_AMP_B_LO, 8'hCD);
    lwr(IO_AMP_B_HI, 8'hFB);
    chk("amp_a", 0, cv_o.amp_a);
    lwr(IO_TRANSFER, 8'h00);
    chk("amp_a", 12'h234, cv_o.amp_a);
    chk("amp_b", 12'hBCD, cv_o.amp_b);
    $display("amplitude test done");
    ccc_host_model_inst.refresh(150, 7'h55);
    n = 0;
    repeat (400) @(posedge clk_i) n += local_clk_e_o;
    chk("local_clk_runs", 1, 16'(n > 0));
    $display("refresh test done");
    lwr(IO_PITCH_A_LO, 8'hFF);
    lwr(IO_PITCH_A_HI, 8'h7F);
    lwr(IO_PITCH_B_LO, 8'hFF);
    lwr(IO_PITCH_B_HI, 8'h6F);
    lwr(IO_CONTROL, 8'h03);
    count_rises(3000);
    // Full pitch: one rise per 64 cycles at octave 7, half as many at octave 6
    chk("rises_a", 1, 16'(n >= 45 && n <= 48));
    chk("rises_b", 1, 16'(nb >= 22 && nb <= 25));
    lwr(IO_CONTROL, 8'h00);
    repeat (200) @(posedge clk_i);
    $display("pitch test done");
    engine_request_i = 1'b1;
    repeat (480) @(posedge clk_i);
    n = 0;
    repeat (480) begin
      @(posedge clk_i);
      #1;
      n += int'(slot_taken_o);
    end
    chk("slot_taken", 60, 16'(n));
    engine_request_i = 1'b0;
    repeat (480) @(posedge clk_i);
    n = 0;
    repeat (480) begin
      @(posedge clk_i);
      #1;
      n += int'(slot_taken_o);
    end
    chk("slot_taken", 0, 16'(n));
    $display("slot test done");
    end_sim();
  end
endmodule // channel_card_control_tb
